// ==== sos_byte_shifter.sv ====
// double-buffered byte shifter: two 8-bit registers, one shifting, one loading.
// assumes the caller only asserts i_shift while the shifter is not empty.
`timescale 1ns/1ps
module sos_byte_shifter
    import sos_pkg::*;
(
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_wr,
    input  wire logic [SOS_BYTE_W-1:0]   i_wdata,
    input  wire logic                    i_shift,
    input  wire logic                    i_switch,
    input  wire logic [SOS_BITPOS_W-1:0] i_bitpos,
    output logic                         o_bit,
    output logic                         o_full,
    output logic                         o_empty
);

    logic [SOS_BYTE_W-1:0] regs_q [2];
    logic [1:0]            valid_q;
    logic [1:0]            valid_d;
    logic                  sel_q;
    logic                  wsel_q;
    logic                  wr_ok;
    logic                  leave;

    assign wr_ok   = i_wr && !o_full;
    assign leave   = i_shift && i_switch;
    assign o_full  = &valid_q;
    assign o_empty = ~|valid_q;
    assign o_bit   = regs_q[sel_q][i_bitpos];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_reg
            always_ff @(posedge i_core_clk) begin
                if (i_rst) begin
                    regs_q[g] <= SOS_BYTE_RST;
                end else if (wr_ok && (wsel_q == 1'(g))) begin
                    regs_q[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // a load into the freed slot in the same cycle wins over the free
    always_comb begin
        valid_d = valid_q;
        if (leave) begin
            valid_d[sel_q] = 1'b0;
        end
        if (wr_ok) begin
            valid_d[wsel_q] = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            valid_q <= 2'h0;
            sel_q   <= 1'b0;
            wsel_q  <= 1'b0;
        end else begin
            valid_q <= valid_d;
            if (leave) begin
                sel_q <= ~sel_q;
            end
            if (wr_ok) begin
                wsel_q <= ~wsel_q;
            end
        end
    end

    a_full_drop: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_wr && o_full |=> (regs_q[0] == $past(regs_q[0])) && (regs_q[1] == $past(regs_q[1])))
        else $error("write to a full shifter changed its contents");

    a_switch_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
        leave |=> sel_q != $past(sel_q))
        else $error("shift register selection did not switch");

endmodule

// ==== sos_chain_model.sv ====
// scan chain seen from the pins: hands on each bit the chain clocks in.
// assumes the test clock is the shift clock gated by the tick enable level.
`timescale 1ns/1ps
module sos_chain_model (
    input  wire logic       i_sck,
    input  wire logic       i_tck_en,
    input  wire logic       i_tms0,
    input  wire logic       i_tms1,
    input  wire logic       i_tdo,
    output logic      [2:0] o_bits,
    output logic            o_seen
);
    logic tick_q = 1'b0;
    initial o_seen = 1'b0;
    // pins settle a few core clocks after a fall, so capture at the next fall
    always @(negedge i_sck) begin
        if (tick_q) begin
            o_bits <= {i_tms1, i_tms0, i_tdo};
            o_seen <= ~o_seen;
        end
        tick_q <= i_tck_en;
    end
endmodule

// ==== sos_pkg.sv ====
// package for the outgoing scan shifters: register map, field positions,
// reset values, widths and small decode helpers.
// assumes an APB master on the core clock and a shift clock arriving on a pin.
package sos_pkg;

    // register byte addresses, one aligned 32-bit word each
    localparam logic [7:0] SOS_ADDR_TDO      = 8'h00;
    localparam logic [7:0] SOS_ADDR_TMS0     = 8'h08;
    localparam logic [7:0] SOS_ADDR_TMS1     = 8'h0C;
    localparam logic [7:0] SOS_ADDR_MODE_A   = 8'h10;
    localparam logic [7:0] SOS_ADDR_MODE_B   = 8'h14;
    localparam logic [7:0] SOS_ADDR_SCAN_LEN = 8'h18;
    localparam logic [7:0] SOS_ADDR_STATUS   = 8'h1C;

    // mode register a field positions
    localparam int unsigned SOS_MA_AUTO_HIGH = 1;
    localparam int unsigned SOS_MA_CNT_EN    = 2;
    localparam int unsigned SOS_MA_TDO_EN    = 4;
    localparam int unsigned SOS_MA_TMS0_EN   = 5;
    localparam int unsigned SOS_MA_TMS1_EN   = 6;

    // mode register b field positions
    localparam int unsigned SOS_MB_LOOP_LO   = 0;
    localparam int unsigned SOS_MB_LOOP_HI   = 1;
    localparam int unsigned SOS_MB_PGEN      = 4;

    // reset values
    localparam logic [7:0]  SOS_MODE_A_RST   = 8'h00;
    localparam logic [7:0]  SOS_MODE_B_RST   = 8'h00;
    localparam logic [31:0] SOS_SCAN_LEN_RST = 32'h0000_0000;
    localparam logic [7:0]  SOS_BYTE_RST     = 8'h00;
    localparam logic [31:0] SOS_PGEN_RST     = 32'h0000_0000;

    // widths and counts
    localparam int unsigned SOS_BYTE_W       = 8;
    localparam int unsigned SOS_BITPOS_W     = 3;
    localparam int unsigned SOS_PGEN_W       = 32;
    localparam logic [2:0]  SOS_BITPOS_LAST  = 3'h7;
    localparam logic [1:0]  SOS_PGEN_LAST_IX = 2'h3;
    localparam logic [31:0] SOS_SCAN_ONE     = 32'h0000_0001;

    typedef enum logic {
        SOS_PGEN_FILL,
        SOS_PGEN_RUN
    } sos_pgen_state_t;

    function automatic logic sos_hit(input logic [7:0] addr, input logic [7:0] target);
        sos_hit = (addr == target);
    endfunction

endpackage

// ==== sos_pseudo_random_generator.sv ====
// 32-bit pattern generator loaded by four byte writes, low byte first.
// the 32 stages stand for the normal byte pair plus two more byte registers.
`timescale 1ns/1ps
module sos_pgen
    import sos_pkg::*;
(
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_restart,
    input  wire logic                  i_wr,
    input  wire logic [SOS_BYTE_W-1:0] i_wdata,
    input  wire logic                  i_step,
    output logic                       o_bit,
    output logic                       o_loaded
);

    sos_pgen_state_t         state_q;
    logic [1:0]              idx_q;
    logic [SOS_PGEN_W-1:0]   lfsr_q;
    logic                    fb;

    // right-shifting form of x^32 + x^22 + x^2 + x + 1
    assign fb       = lfsr_q[0] ^ lfsr_q[10] ^ lfsr_q[30] ^ lfsr_q[31];
    assign o_bit    = lfsr_q[0];
    assign o_loaded = (state_q == SOS_PGEN_RUN);

    always_ff @(posedge i_core_clk) begin
        if (i_rst || i_restart) begin
            state_q <= SOS_PGEN_FILL;
            idx_q   <= 2'h0;
        end else begin
            case (state_q)
                SOS_PGEN_FILL: begin
                    if (i_wr) begin
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == SOS_PGEN_LAST_IX) begin
                            state_q <= SOS_PGEN_RUN;
                        end
                    end
                end
                SOS_PGEN_RUN: begin
                    state_q <= SOS_PGEN_RUN;
                end
                default: begin
                    state_q <= SOS_PGEN_FILL;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lfsr_q <= SOS_PGEN_RST;
        end else if (i_wr && (state_q == SOS_PGEN_FILL) && !i_restart) begin
            lfsr_q[idx_q*8 +: 8] <= i_wdata;
        end else if (i_step && (state_q == SOS_PGEN_RUN)) begin
            lfsr_q <= {fb, lfsr_q[SOS_PGEN_W-1:1]};
        end
    end

    a_pgen_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_step && o_loaded && !i_restart |=> (lfsr_q[30:0] == $past(lfsr_q[31:1]))
            && (lfsr_q[31] == ($past(lfsr_q[0]) ^ $past(lfsr_q[10]) ^ $past(lfsr_q[30]) ^ $past(lfsr_q[31]))))
        else $error("pattern generator step does not follow the polynomial");

    // the fourth byte completes the load whatever spacing the host uses
    a_pgen_fill: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_wr && !o_loaded && !i_restart && (idx_q == SOS_PGEN_LAST_IX) |=> o_loaded)
        else $error("generator not loaded after four writes");

endmodule

// ==== sos_scan_out.sv ====
// outgoing scan section: two mode-select shifters, one test data shifter with
// pattern generator, scan-length and bit-position counters, APB registers.
// assumes the shift clock, device reset and output enable arrive as pins from
// another domain; the shift clock is sampled and its edges found here.
`timescale 1ns/1ps
module sos_scan_out
    import sos_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_sck,
    input  wire logic        i_dev_rst_n,
    input  wire logic        i_oe_n,
    output logic             o_tms0,
    output logic             o_tms0_oe,
    output logic             o_tms1,
    output logic             o_tms1_oe,
    output logic             o_tdo,
    output logic             o_tdo_oe,
    output logic             o_tck_en
);

    // pin synchronisers; logic reads the second stage, and the shift clock's third stage for edges
    logic        sck_s1_q;
    logic        sck_s2_q;
    logic        sck_prev_q;
    logic        rstn_s1_q;
    logic        rstn_s2_q;
    logic        oen_s1_q;
    logic        oen_s2_q;

    logic [7:0]  mode_a_q;
    logic [7:0]  mode_b_q;
    logic [31:0] scan_len_q;
    logic        loaded_q;
    logic [2:0]  bitpos_q;
    logic        pgen_prev_q;
    logic        tms0_q;
    logic        tms1_q;
    logic        tdo_q;
    logic [31:0] prdata_q;

    logic        dev_rst;
    logic        sck_fall;
    logic        tick;
    logic        tck_en;
    logic        last;
    logic        tc;
    logic        do_switch;
    logic        loop_on;
    logic        pgen_on;
    logic        auto_on;
    logic        cnt_en;
    logic        tdo_en;
    logic        tms0_en;
    logic        tms1_en;
    logic        apb_wr;
    logic        apb_setup;
    logic        mapped;
    logic        pgen_restart;

    logic        tdo_bit;
    logic        tdo_full;
    logic        tdo_empty;
    logic        tms0_bit;
    logic        tms0_full;
    logic        tms0_empty;
    logic        tms1_bit;
    logic        tms1_full;
    logic        tms1_empty;
    logic        pgen_bit;
    logic        pgen_loaded;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sck_s1_q   <= 1'b0;
            sck_s2_q   <= 1'b0;
            sck_prev_q <= 1'b0;
            rstn_s1_q  <= 1'b0;
            rstn_s2_q  <= 1'b0;
            oen_s1_q   <= 1'b1;
            oen_s2_q   <= 1'b1;
        end else begin
            sck_s1_q   <= i_sck;
            sck_s2_q   <= sck_s1_q;
            sck_prev_q <= sck_s2_q;
            rstn_s1_q  <= i_dev_rst_n;
            rstn_s2_q  <= rstn_s1_q;
            oen_s1_q   <= i_oe_n;
            oen_s2_q   <= oen_s1_q;
        end
    end

    assign dev_rst  = i_rst || !rstn_s2_q;
    assign sck_fall = sck_prev_q && !sck_s2_q;

    assign loop_on  = mode_b_q[SOS_MB_LOOP_LO] || mode_b_q[SOS_MB_LOOP_HI];
    assign pgen_on  = mode_b_q[SOS_MB_PGEN];
    assign auto_on  = mode_a_q[SOS_MA_AUTO_HIGH];
    assign cnt_en   = mode_a_q[SOS_MA_CNT_EN];
    assign tdo_en   = mode_a_q[SOS_MA_TDO_EN];
    assign tms0_en  = mode_a_q[SOS_MA_TMS0_EN];
    assign tms1_en  = mode_a_q[SOS_MA_TMS1_EN];

    // the shift clock is held low by withholding the enable
    assign tck_en = rstn_s2_q
        && !(tdo_en && (pgen_on ? !pgen_loaded : tdo_empty))
        && !(tms0_en && tms0_empty)
        && !(tms1_en && tms1_empty)
        && !(cnt_en && (!loaded_q || (scan_len_q == SOS_SCAN_LEN_RST)));
    assign o_tck_en = tck_en;

    assign tick      = sck_fall && tck_en;
    assign tc        = cnt_en && loaded_q && (scan_len_q == SOS_SCAN_LEN_RST);
    assign last      = cnt_en && loaded_q && (scan_len_q == SOS_SCAN_ONE);
    assign do_switch = (bitpos_q == SOS_BITPOS_LAST) || last;

    // ---- APB slave, no wait states, unmapped access answers with an error
    assign apb_setup = i_psel && !i_penable;
    assign apb_wr    = i_psel && i_penable && i_pwrite;
    assign o_pready  = 1'b1;
    assign mapped    = sos_hit(i_paddr, SOS_ADDR_TDO) || sos_hit(i_paddr, SOS_ADDR_TMS0)
                    || sos_hit(i_paddr, SOS_ADDR_TMS1) || sos_hit(i_paddr, SOS_ADDR_MODE_A)
                    || sos_hit(i_paddr, SOS_ADDR_MODE_B) || sos_hit(i_paddr, SOS_ADDR_SCAN_LEN)
                    || sos_hit(i_paddr, SOS_ADDR_STATUS);
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign o_prdata  = prdata_q;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup && !i_pwrite) begin
            case (i_paddr)
                SOS_ADDR_MODE_A:   prdata_q <= {24'h000000, mode_a_q};
                SOS_ADDR_MODE_B:   prdata_q <= {24'h000000, mode_b_q};
                SOS_ADDR_SCAN_LEN: prdata_q <= scan_len_q;
                SOS_ADDR_STATUS: begin
                    prdata_q <= {20'h00000, bitpos_q, tck_en, tc, pgen_loaded,
                                 tms1_full, tms1_empty, tms0_full, tms0_empty, tdo_full, tdo_empty};
                end
                default:           prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode_a_q <= SOS_MODE_A_RST;
            mode_b_q <= SOS_MODE_B_RST;
        end else if (apb_wr) begin
            if (sos_hit(i_paddr, SOS_ADDR_MODE_A)) begin
                mode_a_q <= i_pwdata[7:0];
            end
            if (sos_hit(i_paddr, SOS_ADDR_MODE_B)) begin
                mode_b_q <= i_pwdata[7:0];
            end
        end
    end

    // ---- scan-length counter: a new load wins over a decrement in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (dev_rst) begin
            scan_len_q <= SOS_SCAN_LEN_RST;
            loaded_q   <= 1'b0;
        end else if (apb_wr && sos_hit(i_paddr, SOS_ADDR_SCAN_LEN)) begin
            scan_len_q <= i_pwdata;
            loaded_q   <= 1'b1;
        end else if (tick && cnt_en && loaded_q && !tc) begin
            scan_len_q <= scan_len_q - SOS_SCAN_ONE;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (dev_rst) begin
            bitpos_q <= 3'h0;
        end else if (tick) begin
            if (last) begin
                bitpos_q <= 3'h0;
            end else begin
                bitpos_q <= bitpos_q + 3'h1;
            end
        end
    end

    // ---- pattern mode entry restarts the byte loading
    always_ff @(posedge i_core_clk) begin
        if (dev_rst) begin
            pgen_prev_q <= 1'b0;
        end else begin
            pgen_prev_q <= pgen_on;
        end
    end
    assign pgen_restart = pgen_on && !pgen_prev_q;

    sos_byte_shifter u_tdo (
        .i_core_clk (i_core_clk),
        .i_rst      (dev_rst),
        .i_wr       (apb_wr && sos_hit(i_paddr, SOS_ADDR_TDO) && !pgen_on),
        .i_wdata    (i_pwdata[7:0]),
        .i_shift    (tick && tdo_en && !pgen_on),
        .i_switch   (do_switch),
        .i_bitpos   (bitpos_q),
        .o_bit      (tdo_bit),
        .o_full     (tdo_full),
        .o_empty    (tdo_empty)
    );

    sos_byte_shifter u_tms0 (
        .i_core_clk (i_core_clk),
        .i_rst      (dev_rst),
        .i_wr       (apb_wr && sos_hit(i_paddr, SOS_ADDR_TMS0)),
        .i_wdata    (i_pwdata[7:0]),
        .i_shift    (tick && tms0_en),
        .i_switch   (do_switch),
        .i_bitpos   (bitpos_q),
        .o_bit      (tms0_bit),
        .o_full     (tms0_full),
        .o_empty    (tms0_empty)
    );

    sos_byte_shifter u_tms1 (
        .i_core_clk (i_core_clk),
        .i_rst      (dev_rst),
        .i_wr       (apb_wr && sos_hit(i_paddr, SOS_ADDR_TMS1)),
        .i_wdata    (i_pwdata[7:0]),
        .i_shift    (tick && tms1_en),
        .i_switch   (do_switch),
        .i_bitpos   (bitpos_q),
        .o_bit      (tms1_bit),
        .o_full     (tms1_full),
        .o_empty    (tms1_empty)
    );

    sos_pgen u_pgen (
        .i_core_clk (i_core_clk),
        .i_rst      (dev_rst),
        .i_restart  (pgen_restart),
        .i_wr       (apb_wr && sos_hit(i_paddr, SOS_ADDR_TDO) && pgen_on),
        .i_wdata    (i_pwdata[7:0]),
        .i_step     (tick && tdo_en && pgen_on),
        .o_bit      (pgen_bit),
        .o_loaded   (pgen_loaded)
    );

    // ---- pin registers; auto high overrides data on both lines at once,
    // so any idle chain on the other line must sit in its reset state
    always_ff @(posedge i_core_clk) begin
        if (dev_rst) begin
            tms0_q <= 1'b1;
            tms1_q <= 1'b1;
        end else if (tick && !loop_on) begin
            if (auto_on && last) begin
                tms0_q <= 1'b1;
                tms1_q <= 1'b1;
            end else begin
                if (tms0_en) begin
                    tms0_q <= tms0_bit;
                end
                if (tms1_en) begin
                    tms1_q <= tms1_bit;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (dev_rst) begin
            tdo_q <= 1'b1;
        end else if (tick && tdo_en && !loop_on) begin
            tdo_q <= pgen_on ? pgen_bit : tdo_bit;
        end
    end

    assign o_tms0    = tms0_q;
    assign o_tms1    = tms1_q;
    assign o_tdo     = tdo_q;
    assign o_tms0_oe = !oen_s2_q;
    assign o_tms1_oe = !oen_s2_q;
    assign o_tdo_oe  = !oen_s2_q;

    // ---- checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_shift_tick;
        sck_fall && tck_en && rstn_s2_q;
    endsequence

    sequence s_last_bit;
        s_shift_tick ##0 last;
    endsequence

    a_pin_rst_tms: assert property (!rstn_s2_q |=> o_tms0 && o_tms1)
        else $error("mode-select not high during device reset");

    a_pin_rst_tdo: assert property (!rstn_s2_q |=> o_tdo)
        else $error("data out not high during device reset");

    a_oe_float: assert property (oen_s2_q |-> !o_tms0_oe && !o_tms1_oe && !o_tdo_oe)
        else $error("outputs driven while output enable pin is high");

    a_fall_only: assert property (!sck_fall && rstn_s2_q
        |=> $stable(o_tdo) && $stable(o_tms0) && $stable(o_tms1))
        else $error("output changed without a shift clock falling edge");

    a_loop_tdo: assert property (loop_on && rstn_s2_q |=> $stable(o_tdo))
        else $error("data out moved during loop-back");

    a_loop_tms: assert property (loop_on && rstn_s2_q |=> $stable(o_tms0) && $stable(o_tms1))
        else $error("mode-select moved during loop-back");

    a_auto_high: assert property (s_last_bit ##0 (auto_on && !loop_on) |=> o_tms0 && o_tms1)
        else $error("auto high missing on last bit");

    a_tc_bitpos: assert property (s_last_bit ##0 !apb_wr |=> (bitpos_q == 3'h0) && tc && !tck_en)
        else $error("bit counter not cleared at terminal count");

    a_gate_empty: assert property (tdo_en && !pgen_on && tdo_empty |-> !tck_en)
        else $error("shift clock enabled with empty data shifter");

    a_lsb_out: assert property (s_shift_tick ##0 (tdo_en && !pgen_on && !loop_on)
        |=> o_tdo == $past(tdo_bit))
        else $error("data out does not follow the selected bit");

endmodule

// ==== test_sos_scan_out.sv ====
// testbench for the outgoing scan shifters: APB writes, shift clock bursts.
// assumes the chain model reports every bit the chain clocks in.
`timescale 1ns/1ps
module test_sos_scan_out;
    import sos_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, sck = 1, drn = 0, oen = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed = 32'hE5AB;
    logic        pready, pslverr, perr, tms0, tms1, tdo, oe0, oe1, oe2, tck_en, seen;
    logic [2:0]  bits;
    logic [2:0]  exp_q[$];
    int          n_errors = 0, checked = 0;
    initial forever #10 clk = ~clk;
    sos_scan_out dut_u(.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_sck(sck), .i_dev_rst_n(drn), .i_oe_n(oen), .o_tms0(tms0), .o_tms0_oe(oe0), .o_tms1(tms1),
        .o_tms1_oe(oe1), .o_tdo(tdo), .o_tdo_oe(oe2), .o_tck_en(tck_en));
    sos_chain_model chain_u(.i_sck(sck), .i_tck_en(tck_en), .i_tms0(tms0), .i_tms1(tms1), .i_tdo(tdo),
        .o_bits(bits), .o_seen(seen));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        int k;
        psel <= 1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        perr = pslverr;
        if (k >= 50) begin
            n_errors++;
            conclude();
        end
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    // the link clock stands still between frames; n bits need n+1 falls to be seen
    task automatic frame(int n);
        repeat (n + 1) begin
            repeat (4) @(posedge clk);
            sck <= 0;
            repeat (4) @(posedge clk);
            sck <= 1;
        end
        repeat (8) @(posedge clk);
    endtask
    // the model's flag settles from unknown at time zero; that is no bit
    always @(seen) begin
        if ($time > 0) begin
            if (exp_q.size() == 0)
                chk("extra bit", 0, 1);
            else
                chk("pins", exp_q.pop_front(), bits);
        end
    end
    initial begin
        logic [7:0]  b[6];
        logic [7:0]  ad[3];
        logic [31:0] q;
        int          n;
        logic [31:0] w;
        logic [2:0]  h;
        ad = '{SOS_ADDR_TDO, SOS_ADDR_TMS0, SOS_ADDR_TMS1};
        repeat (10) @(posedge clk);
        chk("reset pins", 3'h7, {tms1, tms0, tdo});
        rst <= 0;
        drn <= 1;
        repeat (4) @(posedge clk);
        chk("drive on", 3'h7, {oe0, oe1, oe2});
        for (int r = 0; r < 4; r++) begin
            foreach (b[i]) b[i] = rnd();
            for (int s = 0; s < 3; s++) begin
                apb(1, ad[s], b[s], q);
                apb(1, ad[s], b[s + 3], q);
                apb(1, ad[s], 32'hFF, q);
            end
            apb(0, SOS_ADDR_STATUS, 0, q);
            chk("full flags", 6'h2A, q[5:0]);
            n = rnd() % 7 + 1;
            apb(1, SOS_ADDR_SCAN_LEN, n, q);
            apb(1, SOS_ADDR_MODE_A, 8'h76, q);
            for (int i = 0; i < n; i++)
                exp_q.push_back({b[2][i] | (i == n - 1), b[1][i] | (i == n - 1), b[0][i]});
            frame(n);
            apb(1, SOS_ADDR_SCAN_LEN, 8, q);
            apb(1, SOS_ADDR_MODE_A, 8'h74, q);
            for (int i = 0; i < 8; i++)
                exp_q.push_back({b[5][i], b[4][i], b[3][i]});
            frame(8);
            apb(0, SOS_ADDR_STATUS, 0, q);
            chk("empty, bitpos", 9'h015, {q[11:9], q[5:0]});
        end
        h = {b[5][7], b[4][7], b[3][7]};
        apb(0, 8'h04, 0, q);
        chk("unmapped error", 1, perr);
        chk("unmapped data", 0, q);
        // loop-back: shifters still run, pins keep the last frame's bits
        foreach (b[i]) b[i] = rnd();
        for (int s = 0; s < 3; s++)
            apb(1, ad[s], b[s], q);
        apb(1, SOS_ADDR_SCAN_LEN, 8, q);
        apb(1, SOS_ADDR_MODE_B, 8'h01, q);
        repeat (8) exp_q.push_back(h);
        frame(8);
        // pattern mode with both mode-select shifters disabled
        w = rnd();
        apb(1, SOS_ADDR_MODE_B, 8'h10, q);
        apb(1, SOS_ADDR_MODE_A, 8'h14, q);
        apb(1, SOS_ADDR_SCAN_LEN, 8, q);
        for (int i = 0; i < 3; i++)
            apb(1, SOS_ADDR_TDO, w[i*8 +: 8], q);
        apb(0, SOS_ADDR_STATUS, 0, q);
        chk("gen not loaded", 0, {q[8], q[6]});
        apb(1, SOS_ADDR_TDO, w[31:24], q);
        apb(0, SOS_ADDR_STATUS, 0, q);
        chk("gen loaded", 3, {q[8], q[6]});
        for (int i = 0; i < 8; i++) begin
            exp_q.push_back({h[2:1], w[0]});
            w = {w[0] ^ w[10] ^ w[30] ^ w[31], w[31:1]};
        end
        frame(8);
        chk("left over", 0, exp_q.size());
        chk("held pins", {bits}, {tms1, tms0, tdo});
        oen <= 1;
        repeat (5) @(posedge clk);
        chk("drive off", 3'h0, {oe0, oe1, oe2});
        drn <= 0;
        repeat (5) @(posedge clk);
        chk("forced high", 3'h7, {tms1, tms0, tdo});
        conclude();
    end
endmodule
